// ---- hw/counter_array_pkg.sv ----
/*
 Constants, register map, field positions and types shared by the counter
 array. Assumes a 32-bit APB master on a single 20 MHz clock.
*/
package counter_array_pkg;
    localparam int ADDR_W = 8;
    localparam int NUM_CH = 6;
    localparam int SYSCLK_HZ = 20000000;
    localparam int DIV_SLOW = 12;
    localparam int DIV_FAST = 4;

    // byte addresses, one aligned word each
    localparam logic [7:0] OFF_COUNT_LOW = 8'h00;
    localparam logic [7:0] OFF_COUNT_HIGH = 8'h04;
    localparam logic [7:0] OFF_ARRAY_MODE = 8'h08;
    localparam logic [7:0] OFF_CONTROL = 8'h0C;
    localparam logic [7:0] OFF_PWM_CTRL = 8'h10;
    localparam logic [3:0] CHAN_BASE_ROW = 4'h2;
    localparam logic [3:0] CHAN_MODE = 4'h0;
    localparam logic [3:0] CHAN_LOW = 4'h4;
    localparam logic [3:0] CHAN_HIGH = 4'h8;

    // array_mode_reg fields
    localparam int AM_IDLE_HALT = 7;
    localparam int AM_WATCHDOG = 6;
    localparam int AM_TB_LSB = 1;
    localparam int AM_OVF_IRQ_EN = 0;
    localparam logic [7:0] AM_RESET = 8'h40;

    // control register fields, channel flags in bits 5..0
    localparam int CT_OVF_FLAG = 7;
    localparam int CT_RUN = 6;

    // pwm_control_reg fields
    localparam int PW_RELOAD_SEL = 7;
    localparam int PW_CYC_FLAG = 6;
    localparam int PW_CYC_IRQ_EN = 5;

    localparam logic [15:0] MASK_8 = 16'h00FF;
    localparam logic [15:0] MASK_9 = 16'h01FF;
    localparam logic [15:0] MASK_10 = 16'h03FF;
    localparam logic [15:0] MASK_11 = 16'h07FF;
    localparam logic [15:0] MASK_16 = 16'hFFFF;
    localparam logic [15:0] COUNT_ONE = 16'h0001;

    typedef enum logic [2:0] {
        TB_DIV12 = 3'b000,
        TB_DIV4 = 3'b001,
        TB_TIMER0 = 3'b010,
        TB_EXT_EDGE = 3'b011,
        TB_SYSCLK = 3'b100,
        TB_EXT_OSC = 3'b101,
        TB_RTC_OSC = 3'b110,
        TB_RESERVED = 3'b111
    } timebase_e;

    typedef struct packed {
        logic pwm16;
        logic comparator_en;
        logic rise_capture_en;
        logic fall_capture_en;
        logic match_flag_en;
        logic toggle_en;
        logic pwm_en;
        logic channel_irq_en;
    } chan_mode_s;
endpackage

// ---- hw/counter_array.sv ----
/*
 Programmable counter array: 16-bit counter, timebase selector and six
 capture/compare channels, registers over APB. Assumes pins and the divided
 oscillator inputs are asynchronous; timer0_overflow is a pclk pulse.
*/
// Our own choices: the placing of the registers and register access over APB.
module counter_array (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [counter_array_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic timer0_overflow,
    input wire logic ext_count_input,
    input wire logic ext_osc_div8,
    input wire logic rtc_osc_div8,
    input wire logic cpu_idle,
    input wire logic [counter_array_pkg::NUM_CH-1:0] channel_pin_in,
    output logic [counter_array_pkg::NUM_CH-1:0] channel_pin_out,
    output logic [counter_array_pkg::NUM_CH-1:0] channel_pin_oe,
    output logic irq
);
    localparam int N = counter_array_pkg::NUM_CH;
    localparam int WD_CH = 5;

    function automatic logic [15:0] cycle_mask(input logic pwm16, input logic [1:0] cls);
        logic [15:0] m;
        m = counter_array_pkg::MASK_11;
        if (pwm16)
            m = counter_array_pkg::MASK_16;
        else if (cls == 2'b00)
            m = counter_array_pkg::MASK_8;
        else if (cls == 2'b01)
            m = counter_array_pkg::MASK_9;
        else if (cls == 2'b10)
            m = counter_array_pkg::MASK_10;
        return m;
    endfunction

    logic [15:0] counter;
    logic [7:0] snapshot;

    logic [7:0] array_mode;
    logic run;
    logic ovf_flag;
    logic [N-1:0] chan_flag;
    logic [7:0] pwm_ctrl;
    logic [3:0] div_slow;
    logic [1:0] div_fast;

    logic [1:0] ext_sync;
    logic [1:0] xosc_sync;
    logic [1:0] rtc_sync;
    logic ext_prev;
    logic xosc_prev;
    logic rtc_prev;

    logic [1:0] pin_sync [N];
    logic [N-1:0] pin_prev;

    logic [15:0] ccr [N];
    logic [15:0] arr [N];
    counter_array_pkg::chan_mode_s mode [N];
    logic [N-1:0] chan_event;

    // bus decode
    wire access = psel && penable;
    wire [3:0] row = paddr[7:4];
    wire [3:0] col = paddr[3:0];
    wire chan_row = (row >= counter_array_pkg::CHAN_BASE_ROW)
        && (row < counter_array_pkg::CHAN_BASE_ROW + 4'(N));
    wire [2:0] chan_idx = 3'(row - counter_array_pkg::CHAN_BASE_ROW);

    wire chan_hit = chan_row && (col == counter_array_pkg::CHAN_MODE
        || col == counter_array_pkg::CHAN_LOW || col == counter_array_pkg::CHAN_HIGH);
    wire hit_low = paddr == counter_array_pkg::OFF_COUNT_LOW;
    wire hit_high = paddr == counter_array_pkg::OFF_COUNT_HIGH;
    wire hit_mode = paddr == counter_array_pkg::OFF_ARRAY_MODE;
    wire hit_ctrl = paddr == counter_array_pkg::OFF_CONTROL;
    wire hit_pwm = paddr == counter_array_pkg::OFF_PWM_CTRL;
    wire addr_ok = hit_low || hit_high || hit_mode || hit_ctrl || hit_pwm || chan_hit;

    wire wr_en = access && pwrite && addr_ok;
    wire rd_en = access && !pwrite && addr_ok;
    wire [7:0] wbyte = pwdata[7:0];

    // zero wait states: every register answers in its access phase
    assign pready = 1'b1;
    assign pslverr = access && !addr_ok;

    // configuration fields
    wire idle_halt_ctrl = array_mode[counter_array_pkg::AM_IDLE_HALT];
    wire watchdog_on = array_mode[counter_array_pkg::AM_WATCHDOG];
    wire [2:0] timebase_select = array_mode[counter_array_pkg::AM_TB_LSB +: 3];
    wire counter_overflow_irq_en = array_mode[counter_array_pkg::AM_OVF_IRQ_EN];

    wire reload_access_sel = pwm_ctrl[counter_array_pkg::PW_RELOAD_SEL];
    wire cycle_overflow_flag = pwm_ctrl[counter_array_pkg::PW_CYC_FLAG];
    wire cycle_overflow_irq_en = pwm_ctrl[counter_array_pkg::PW_CYC_IRQ_EN];
    wire [1:0] cycle_length_sel = pwm_ctrl[1:0];

    // synchronised edges; only the second stage feeds logic
    wire ext_fall = ext_prev && !ext_sync[1];
    wire xosc_rise = !xosc_prev && xosc_sync[1];
    wire rtc_rise = !rtc_prev && rtc_sync[1];

    // timebase selection
    logic src_tick;
    always_comb
    begin
        case (counter_array_pkg::timebase_e'(timebase_select))
            counter_array_pkg::TB_DIV12: src_tick = div_slow == 4'(counter_array_pkg::DIV_SLOW - 1);
            counter_array_pkg::TB_DIV4: src_tick = div_fast == 2'(counter_array_pkg::DIV_FAST - 1);
            counter_array_pkg::TB_TIMER0: src_tick = timer0_overflow;
            counter_array_pkg::TB_EXT_EDGE: src_tick = ext_fall;
            counter_array_pkg::TB_SYSCLK: src_tick = 1'b1;
            counter_array_pkg::TB_EXT_OSC: src_tick = xosc_rise;
            counter_array_pkg::TB_RTC_OSC: src_tick = rtc_rise;
            default: src_tick = 1'b0;
        endcase
    end

    // idle only stops the array when idle_halt_ctrl is set
    wire tick = src_tick && run && !(idle_halt_ctrl && cpu_idle);
    wire [15:0] next_count = counter + counter_array_pkg::COUNT_ONE;

    wire counter_wrap = tick && counter == counter_array_pkg::MASK_16;
    wire [15:0] shared_mask = cycle_mask(1'b0, cycle_length_sel);
    wire cycle_wrap = tick && (counter & shared_mask) == shared_mask;

    // watchdog mode freezes the mode register, except its watchdog bit, and channel five
    wire wd_lock = watchdog_on;
    // locked writes drop silently, no bus error is raised

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            div_slow <= 4'h0;
            div_fast <= 2'h0;
            ext_sync <= 2'h3;
            xosc_sync <= 2'h0;
            rtc_sync <= 2'h0;
            ext_prev <= 1'b1;
            xosc_prev <= 1'b0;
            rtc_prev <= 1'b0;
        end
        else
        begin
            div_slow <= (div_slow == 4'(counter_array_pkg::DIV_SLOW - 1)) ? 4'h0 : div_slow + 4'h1;
            div_fast <= div_fast + 2'h1;
            ext_sync <= {ext_sync[0], ext_count_input};
            xosc_sync <= {xosc_sync[0], ext_osc_div8};
            rtc_sync <= {rtc_sync[0], rtc_osc_div8};

            ext_prev <= ext_sync[1];
            xosc_prev <= xosc_sync[1];
            rtc_prev <= rtc_sync[1];
        end
    end

    // counter and snapshot; software writes win over a tick
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            counter <= 16'h0000;
            snapshot <= 8'h00;
        end
        else
        begin
            if (wr_en && hit_low)
                counter[7:0] <= wbyte;
            else if (tick)
                counter[7:0] <= next_count[7:0];
            if (wr_en && hit_high)
                counter[15:8] <= wbyte;
            else if (tick)
                counter[15:8] <= next_count[15:8];
            // a high read alone never refreshes the copy
            if (rd_en && hit_low)
                snapshot <= counter[15:8];
        end
    end

    // mode, control and pwm control registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            array_mode <= counter_array_pkg::AM_RESET;
            run <= 1'b0;
            ovf_flag <= 1'b0;
            chan_flag <= '0;
            pwm_ctrl <= 8'h00;
        end
        else
        begin
            if (wr_en && hit_mode)
            begin
                if (wd_lock)
                    array_mode[counter_array_pkg::AM_WATCHDOG] <= wbyte[counter_array_pkg::AM_WATCHDOG];
                else
                    array_mode <= wbyte;
            end

            if (wr_en && hit_ctrl)
                run <= wbyte[counter_array_pkg::CT_RUN];
            // write one to clear; a same-cycle event wins
            ovf_flag <= counter_wrap
                || (ovf_flag && !(wr_en && hit_ctrl && wbyte[counter_array_pkg::CT_OVF_FLAG]));
            chan_flag <= chan_event
                | (chan_flag & ~((wr_en && hit_ctrl) ? wbyte[N-1:0] : '0));

            if (wr_en && hit_pwm)
            begin
                pwm_ctrl[7] <= wbyte[7];
                pwm_ctrl[5:0] <= wbyte[5:0];
            end
            pwm_ctrl[counter_array_pkg::PW_CYC_FLAG] <= cycle_wrap
                || (cycle_overflow_flag
                && !(wr_en && hit_pwm && wbyte[counter_array_pkg::PW_CYC_FLAG]));
        end
    end

    genvar ch;
    generate
        for (ch = 0; ch < N; ch++)
        begin : g_chan
            counter_array_pkg::chan_mode_s m;
            assign m = mode[ch];
            wire sel = wr_en && chan_hit && chan_idx == 3'(ch) && !(wd_lock && ch == WD_CH);
            wire wr_mode = sel && col == counter_array_pkg::CHAN_MODE;
            wire wr_lo = sel && col == counter_array_pkg::CHAN_LOW;
            wire wr_hi = sel && col == counter_array_pkg::CHAN_HIGH;

            // second stage feeds the edge detector, never the first
            wire pin_rise = !pin_prev[ch] && pin_sync[ch][1];
            wire pin_fall = pin_prev[ch] && !pin_sync[ch][1];

            wire compare_off = !m.rise_capture_en && !m.fall_capture_en;
            wire capture_mode = !compare_off && !m.match_flag_en && !m.toggle_en && !m.pwm_en;
            wire timer_mode = compare_off && m.match_flag_en && !m.toggle_en && !m.pwm_en;
            wire toggle_mode = compare_off && m.match_flag_en && m.toggle_en && !m.pwm_en;
            wire freq_mode = compare_off && m.toggle_en && m.pwm_en;
            wire pwm_mode = compare_off && !m.toggle_en && m.pwm_en;
            wire pwm_small = pwm_mode && !m.pwm16 && cycle_length_sel == 2'b00;
            wire [15:0] pmask = cycle_mask(m.pwm16, cycle_length_sel);

            // matches fire as the counter steps onto the compare value
            wire match16 = tick && next_count == ccr[ch];
            wire match_lo = tick && next_count[7:0] == ccr[ch][7:0];
            wire pwm_match = tick && (next_count & pmask) == (ccr[ch] & pmask);
            wire pwm_wrap = tick && (counter & pmask) == pmask;
            wire capture = capture_mode
                && ((pin_rise && m.rise_capture_en) || (pin_fall && m.fall_capture_en));
            wire compare_hit = pwm_mode ? pwm_match : match16;

            assign chan_event[ch] = capture
                || (m.comparator_en && m.match_flag_en && compare_off && compare_hit);
            assign channel_pin_oe[ch] = toggle_mode || freq_mode || pwm_mode;

            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    pin_sync[ch] <= 2'h0;
                    pin_prev[ch] <= 1'b0;
                    mode[ch] <= '0;
                    ccr[ch] <= 16'h0000;
                    arr[ch] <= 16'h0000;
                    channel_pin_out[ch] <= 1'b0;
                end
                else
                begin
                    pin_sync[ch] <= {pin_sync[ch][0], channel_pin_in[ch]};
                    pin_prev[ch] <= pin_sync[ch][1];
                    // a capture beats any reload in the same cycle
                    if (capture)
                        ccr[ch] <= counter;
                    else if (freq_mode && m.comparator_en && match_lo)
                        ccr[ch][7:0] <= ccr[ch][7:0] + ccr[ch][15:8];
                    else if (pwm_small && pwm_wrap)
                        ccr[ch][7:0] <= ccr[ch][15:8];
                    else if (pwm_mode && !m.pwm16 && pwm_wrap)
                        ccr[ch] <= arr[ch];

                    // comparator off: toggles hold, pwm forced low
                    if (!m.comparator_en)
                        channel_pin_out[ch] <= pwm_mode ? 1'b0 : channel_pin_out[ch];
                    else if (toggle_mode && match16)
                        channel_pin_out[ch] <= !channel_pin_out[ch];
                    else if (freq_mode && match_lo)
                        channel_pin_out[ch] <= !channel_pin_out[ch];
                    else if (pwm_mode && pwm_match)
                        channel_pin_out[ch] <= 1'b1;
                    else if (pwm_mode && pwm_wrap)
                        channel_pin_out[ch] <= 1'b0;

                    if (wr_mode)
                        mode[ch] <= counter_array_pkg::chan_mode_s'(wbyte);
                    if (wr_lo)
                    begin
                        mode[ch].comparator_en <= 1'b0;
                        if (reload_access_sel)
                            arr[ch][7:0] <= wbyte;
                        else
                            ccr[ch][7:0] <= wbyte;
                    end
                    if (wr_hi)
                    begin
                        mode[ch].comparator_en <= 1'b1;
                        if (reload_access_sel)
                            arr[ch][15:8] <= wbyte;
                        else
                            ccr[ch][15:8] <= wbyte;
                    end
                end
            end
        end
    endgenerate

    // read path
    logic [7:0] chan_byte;
    logic [7:0] rbyte;
    logic [N-1:0] irq_en_vec;

    always_comb
    begin
        chan_byte = 8'h00;
        for (int i = 0; i < N; i++)
        begin
            irq_en_vec[i] = mode[i].channel_irq_en;
            if (chan_idx == 3'(i))
            begin
                if (col == counter_array_pkg::CHAN_MODE)
                    chan_byte = mode[i];
                else if (col == counter_array_pkg::CHAN_LOW)
                    chan_byte = reload_access_sel ? arr[i][7:0] : ccr[i][7:0];
                else
                    chan_byte = reload_access_sel ? arr[i][15:8] : ccr[i][15:8];
            end
        end
    end

    always_comb
    begin
        rbyte = 8'h00;
        if (hit_low)
            rbyte = counter[7:0];
        else if (hit_high)
            rbyte = snapshot;
        else if (hit_mode)
            rbyte = array_mode;
        else if (hit_ctrl)
            rbyte = {ovf_flag, run, chan_flag};
        else if (hit_pwm)
            rbyte = pwm_ctrl;
        else if (chan_hit)
            rbyte = chan_byte;
    end

    assign prdata = {24'h000000, rbyte};

    // enables gate only the request, never the flags
    assign irq = (ovf_flag && counter_overflow_irq_en)
        || (cycle_overflow_flag && cycle_overflow_irq_en)
        || |(chan_flag & irq_en_vec);
endmodule

// ---- verification/counter_array_sva.sv ----
/*
 Port checker for the counter array: APB answers, snapshot reads, sticky irq.
 Assumes the bind below attaches it to every counter_array instance.
*/
module counter_array_sva (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [counter_array_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [counter_array_pkg::NUM_CH-1:0] channel_pin_out,
    input wire logic [counter_array_pkg::NUM_CH-1:0] channel_pin_oe,
    input wire logic irq
);
    logic [7:0] snap;
    logic snap_ok;
    wire acc = psel && penable;
    wire hi_rd = acc && !pwrite && paddr == counter_array_pkg::OFF_COUNT_HIGH;
    wire cnt_acc = acc && (paddr == counter_array_pkg::OFF_COUNT_LOW || paddr == 8'h04);
    wire unmapped = acc && (paddr == 8'h14 || paddr == 8'h1C || paddr == 8'h2C);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // reference copy of what a repeated high read must return
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            snap_ok <= 1'b0;
        else if (hi_rd)
            snap_ok <= 1'b1;
        else if (cnt_acc)
            snap_ok <= 1'b0;
    end
    always_ff @(posedge pclk)
    begin
        if (hi_rd)
            snap <= prdata[7:0];
    end
    chk_ready_high: assert property (pready)
        else $error("pready low");
    chk_upper_zero: assert property (acc |-> prdata[31:8] == 24'h000000)
        else $error("read data above byte not zero");
    chk_unmapped_err: assert property (unmapped |-> pslverr && prdata == 32'h00000000)
        else $error("unmapped access not refused");
    chk_mapped_ok: assert property (acc && paddr <= 8'h10 && paddr[1:0] == 2'b00 |-> !pslverr)
        else $error("mapped access refused");
    chk_snapshot_hold: assert property (hi_rd && snap_ok |-> prdata[7:0] == snap)
        else $error("high byte changed without low read");
    chk_irq_sticky: assert property (irq && !(acc && pwrite) |=> irq)
        else $error("irq dropped without software write");
    chk_reset_quiet: assert property ($rose(presetn) |-> !irq && channel_pin_out == 6'h00)
        else $error("outputs active after reset");
    chk_oe_on_write: assert property (!(acc && pwrite) |=> $stable(channel_pin_oe))
        else $error("pin enable changed without write");
endmodule

bind counter_array counter_array_sva counter_array_sva_inst (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .channel_pin_out(channel_pin_out),
    .channel_pin_oe(channel_pin_oe),
    .irq(irq)
);

// ---- verification/pin_model.sv ----
/*
 Outside world of the counter array: channel pins, edge input, oscillators.
 Assumes the bench calls its tasks; lines stand still between events.
*/
module pin_model (
    input wire logic pclk,
    input wire logic [5:0] pin_out,
    input wire logic [5:0] pin_oe,
    output logic [5:0] pin_in,
    output logic ext_edge,
    output logic ext_osc,
    output logic rtc_osc
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [5:0] drv = 6'h00;
    // a driven pin reads back what the block puts out
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & drv);
    initial
    begin
        ext_edge = 1'b1;
        ext_osc = 1'b0;
        rtc_osc = 1'b0;
    end
    task automatic set_pin(input int k, input logic v);
        @(posedge pclk);
        drv[k] <= v;
        repeat (3) @(posedge pclk);
    endtask
    // one event per 8 clocks, twice the closest allowed spacing
    task automatic pulses(input int sel, input int n);
        repeat (n)
        begin
            @(posedge pclk);
            if (sel == 0)
                ext_edge <= 1'b0;
            else if (sel == 1)
                ext_osc <= 1'b1;
            else
                rtc_osc <= 1'b1;
            repeat (4) @(posedge pclk);
            ext_edge <= 1'b1;
            ext_osc <= 1'b0;
            rtc_osc <= 1'b0;
            repeat (3) @(posedge pclk);
        end
    endtask
endmodule

// ---- verification/testbench.sv ----
/*
 Self-checking bench for the counter array over APB.
 Assumes pin_model on the pins and the bound port checker.
*/
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic timer0_overflow = 1'b0;
    logic cpu_idle = 1'b0;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic pready;
    logic pslverr;
    logic slv;
    logic irq;
    logic [5:0] pin_in;
    logic [5:0] pin_out;
    logic [5:0] pin_oe;
    logic ext_edge;
    logic ext_osc;
    logic rtc_osc;
    logic [15:0] v;
    int errors = 0;
    int samples_checked = 0;
    always #25 pclk = ~pclk;
    counter_array counter_array_inst (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .timer0_overflow(timer0_overflow),
        .ext_count_input(ext_edge),
        .ext_osc_div8(ext_osc),
        .rtc_osc_div8(rtc_osc),
        .cpu_idle(cpu_idle),
        .channel_pin_in(pin_in),
        .channel_pin_out(pin_out),
        .channel_pin_oe(pin_oe),
        .irq(irq)
    );
    pin_model pin_model_inst (
        .pclk(pclk),
        .pin_out(pin_out),
        .pin_oe(pin_oe),
        .pin_in(pin_in),
        .ext_edge(ext_edge),
        .ext_osc(ext_osc),
        .rtc_osc(rtc_osc)
    );
    task automatic finish_test();
        $display("checked %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic cmp8(input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            errors++;
            $display("CHECK FAILED at %0t exp %h got %h", $time, exp, got);
        end
    endtask
    task automatic cmp1(input logic exp, input logic got);
        cmp8({7'h00, exp}, {7'h00, got});
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (n >= 20)
        begin
            errors++;
            finish_test();
        end
        rd = prdata;
        slv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdb(input logic [7:0] a);
        apb(1'b0, a, 8'h00);
    endtask
    task automatic get_count();
        rdb(8'h00);
        v[7:0] = rd[7:0];
        rdb(8'h04);
        v[15:8] = rd[7:0];
    endtask
    task automatic t_reset();
        rdb(8'h08);
        cmp8(counter_array_pkg::AM_RESET, rd[7:0]);
        rdb(8'h0C);
        cmp8(8'h00, rd[7:0]);
        get_count();
        cmp8(8'h00, v[15:8] | v[7:0]);
        apb(1'b1, 8'h70, 8'h4C);
        rdb(8'h70);
        cmp8(8'h00, rd[7:0]);
        rdb(8'h14);
        cmp1(1'b1, slv);
        apb(1'b1, 8'h08, 8'h00);
        rdb(8'h08);
        cmp8(8'h00, rd[7:0]);
        $display("test reset done");
    endtask
    task automatic t_timebase();
        logic [7:0] modes [8] = '{8'h00, 8'h02, 8'h08, 8'h04, 8'h06, 8'h0A, 8'h0C, 8'h88};
        logic [7:0] exps [8] = '{8'd1, 8'd3, 8'd12, 8'd3, 8'd2, 8'd2, 8'd2, 8'd0};
        logic [7:0] l0;
        foreach (modes[i])
        begin
            apb(1'b1, 8'h08, modes[i]);
            apb(1'b1, 8'h0C, 8'h40);
            rdb(8'h00);
            l0 = rd[7:0];
            case (modes[i][3:1])
                3'b010: repeat (3)
                begin
                    @(posedge pclk);
                    timer0_overflow <= 1'b1;
                    @(posedge pclk);
                    timer0_overflow <= 1'b0;
                end
                3'b011: pin_model_inst.pulses(0, 2);
                3'b101: pin_model_inst.pulses(1, 2);
                3'b110: pin_model_inst.pulses(2, 2);
                default: repeat (3) rdb(8'h00);
            endcase
            rdb(8'h00);
            cmp8(exps[i], rd[7:0] - l0);
        end
        $display("test timebase done");
    endtask
    task automatic t_overflow();
        apb(1'b1, 8'h08, 8'h08);
        apb(1'b1, 8'h0C, 8'h40);
        repeat (65600) @(posedge pclk);
        get_count();
        rdb(8'h04);
        cmp8(v[15:8], rd[7:0]);
        apb(1'b1, 8'h0C, 8'h00);
        rdb(8'h0C);
        cmp1(1'b1, rd[7]);
        rdb(8'h10);
        cmp1(1'b1, rd[6]);
        cmp1(1'b0, irq);
        rdb(8'h0C);
        cmp1(1'b1, rd[7]);
        apb(1'b1, 8'h08, 8'h09);
        @(negedge pclk);
        cmp1(1'b1, irq);
        apb(1'b1, 8'h0C, 8'hBF);
        @(negedge pclk);
        cmp1(1'b0, irq);
        apb(1'b1, 8'h10, 8'h20);
        @(negedge pclk);
        cmp1(1'b1, irq);
        apb(1'b1, 8'h10, 8'h60);
        @(negedge pclk);
        cmp1(1'b0, irq);
        $display("test overflow done");
    endtask
    task automatic t_capture();
        logic [7:0] modes [3] = '{8'h21, 8'h11, 8'h31};
        logic rise [3] = '{1'b1, 1'b0, 1'b1};
        logic fall [3] = '{1'b0, 1'b1, 1'b1};
        get_count();
        foreach (modes[i])
        begin
            apb(1'b1, 8'h20, modes[i]);
            pin_model_inst.set_pin(0, 1'b1);
            rdb(8'h0C);
            cmp1(rise[i], rd[0]);
            cmp1(rise[i], irq);
            apb(1'b1, 8'h0C, 8'h01);
            pin_model_inst.set_pin(0, 1'b0);
            rdb(8'h0C);
            cmp1(fall[i], rd[0]);
            apb(1'b1, 8'h0C, 8'h01);
            rdb(8'h24);
            cmp8(v[7:0], rd[7:0]);
            rdb(8'h28);
            cmp8(v[15:8], rd[7:0]);
        end
        $display("test capture done");
    endtask
    task automatic t_compare();
        logic [15:0] c;
        get_count();
        c = v + 16'd40;
        apb(1'b1, 8'h30, 8'h4C);
        apb(1'b1, 8'h34, c[7:0]);
        rdb(8'h30);
        cmp8(8'h0C, rd[7:0]);
        apb(1'b1, 8'h38, c[15:8]);
        rdb(8'h30);
        cmp8(8'h4C, rd[7:0]);
        apb(1'b1, 8'h0C, 8'h40);
        repeat (60) @(posedge pclk);
        apb(1'b1, 8'h0C, 8'h00);
        rdb(8'h0C);
        cmp1(1'b1, rd[1]);
        cmp1(1'b1, pin_out[1]);
        cmp1(1'b1, pin_oe[1]);
        $display("test compare done");
    endtask
    task automatic t_pwm();
        apb(1'b1, 8'h10, 8'h80);
        apb(1'b1, 8'h44, 8'h5A);
        rdb(8'h44);
        cmp8(8'h5A, rd[7:0]);
        apb(1'b1, 8'h10, 8'h00);
        apb(1'b1, 8'h40, 8'h42);
        apb(1'b1, 8'h44, 8'h01);
        apb(1'b1, 8'h48, 8'h01);
        apb(1'b1, 8'h0C, 8'h40);
        repeat (300) @(posedge pclk);
        apb(1'b1, 8'h0C, 8'h00);
        rdb(8'h00);
        cmp1(rd[7:0] != 8'h00, pin_out[2]);
        apb(1'b1, 8'h44, 8'h01);
        @(posedge pclk);
        @(negedge pclk);
        cmp1(1'b0, pin_out[2]);
        $display("test pwm done");
    endtask
    initial
    begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        cpu_idle <= 1'b1;
        t_reset();
        t_timebase();
        t_overflow();
        t_capture();
        t_compare();
        t_pwm();
        finish_test();
    end
endmodule
